/* hdl/fpe_flash_prog_erase_control.sv */
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps

module fpe_flash_prog_erase_control (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   hw_write_gate_pin,
   input  wire logic [2:0]             op_mode,
   input  wire logic                   flash_enabled,
   input  wire logic                   hw_standby,
   input  wire logic                   sw_standby,
   input  wire logic [3:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_write,
   input  wire logic                   reg_read,
   output logic      [7:0]             reg_rdata,
   input  wire logic [16:0]            erase_addr,
   output logic                        erase_allowed,
   output fpe_pkg::fpe_flash_ctl_type  flash_ctl
);

   fpe_pkg::fpe_state_type state_q;
   fpe_pkg::fpe_state_type state_d;
   fpe_pkg::fpe_bus_req_type req;

   // which block an address falls in, one-hot; zero outside the array
   function automatic logic [7:0] block_of(input logic [16:0] a);
      logic [7:0] hit;
      hit = 8'h00;
      if (a >= fpe_pkg::BLOCK_BASE_7 && a <= fpe_pkg::ARRAY_END) begin
         hit = 8'h80;
      end else if (a >= fpe_pkg::BLOCK_BASE_6) begin
         hit = 8'h40;
      end else if (a >= fpe_pkg::BLOCK_BASE_5) begin
         hit = 8'h20;
      end else if (a >= fpe_pkg::BLOCK_BASE_4) begin
         hit = 8'h10;
      end else if (a >= fpe_pkg::BLOCK_BASE_3) begin
         hit = 8'h08;
      end else if (a >= fpe_pkg::BLOCK_BASE_2) begin
         hit = 8'h04;
      end else if (a >= fpe_pkg::BLOCK_BASE_1) begin
         hit = 8'h02;
      end else if (a >= fpe_pkg::BLOCK_BASE_0) begin
         hit = 8'h01;
      end
      return hit;
   endfunction

   logic       init_ctl;
   logic       pin_bit;
   logic       gate_ok;
   logic       mode6;
   logic       blk_writable;
   logic [7:0] cur;
   logic [7:0] nxt;
   logic [7:0] wd;

   always_comb begin
      req.write = reg_write;
      req.read  = reg_read;
      req.addr  = reg_addr;
      req.wdata = reg_wdata;
   end

   always_comb begin
      state_d      = state_q;
      init_ctl     = reset || hw_standby || sw_standby;
      mode6        = (op_mode == fpe_pkg::OP_MODE_6);
      pin_bit      = hw_write_gate_pin;
      cur          = state_q.mode_ctrl;
      wd           = req.wdata;
      nxt          = cur;
      gate_ok      = pin_bit && cur[fpe_pkg::SOFT_GATE_BIT];
      blk_writable = (op_mode == fpe_pkg::OP_MODE_5)
                     || (op_mode == fpe_pkg::OP_MODE_7);
      if (req.write && req.addr == fpe_pkg::MODE_CTRL_OFS
          && flash_enabled) begin
         // each bit only moves when its own interlock holds
         if (pin_bit) begin
            nxt[fpe_pkg::SOFT_GATE_BIT] = wd[fpe_pkg::SOFT_GATE_BIT];
         end
         if (gate_ok) begin
            nxt[fpe_pkg::ERASE_SETUP_BIT] = wd[fpe_pkg::ERASE_SETUP_BIT];
            nxt[fpe_pkg::PROG_SETUP_BIT]  = wd[fpe_pkg::PROG_SETUP_BIT];
            nxt[fpe_pkg::ERASE_CHECK_BIT] = wd[fpe_pkg::ERASE_CHECK_BIT];
            nxt[fpe_pkg::PROG_CHECK_BIT]  = wd[fpe_pkg::PROG_CHECK_BIT];
            if (cur[fpe_pkg::ERASE_SETUP_BIT]) begin
               nxt[fpe_pkg::ERASE_BIT] = wd[fpe_pkg::ERASE_BIT];
            end
            if (cur[fpe_pkg::PROG_SETUP_BIT]) begin
               nxt[fpe_pkg::PROG_BIT] = wd[fpe_pkg::PROG_BIT];
            end
         end
         // refused bits simply keep cur, others take the write, except that in mode 6 a write can only clear bits
         if (mode6) begin
            nxt = nxt & cur;
         end
      end
      // losing the pin drops everything it guards, like a fresh reset
      if (!pin_bit) begin
         nxt[6:0] = 7'h00;
      end
      nxt[fpe_pkg::HW_GATE_BIT] = pin_bit;
      if (init_ctl) begin
         nxt = pin_bit ? fpe_pkg::MODE_CTRL_RST_HI
                       : fpe_pkg::MODE_CTRL_RST_LO;
      end
      state_d.mode_ctrl = nxt;

      if (req.write && req.addr == fpe_pkg::BLOCK_SEL_OFS && flash_enabled
          && blk_writable && gate_ok) begin
         state_d.block_sel = wd;
      end
      if (init_ctl || !pin_bit || !nxt[fpe_pkg::SOFT_GATE_BIT]) begin
         state_d.block_sel = fpe_pkg::BLOCK_SEL_RST;
      end

      // read data stand only in the cycle after the strobe
      state_d.rdata = fpe_pkg::READ_ZERO;
      if (req.read) begin
         case (req.addr)
            fpe_pkg::MODE_CTRL_OFS: begin
               state_d.rdata = flash_enabled ? cur
                                             : fpe_pkg::READ_ZERO;
            end
            fpe_pkg::BLOCK_SEL_OFS: begin
               state_d.rdata = state_q.block_sel;
            end
            fpe_pkg::STATUS_OFS: begin
               state_d.rdata = {6'h00, state_q.phase};
            end
            default: begin
               state_d.rdata = fpe_pkg::READ_ZERO;
            end
         endcase
      end

      // phase summary for software, read back at STATUS_OFS
      case (state_q.phase)
         fpe_pkg::FPE_IDLE,
         fpe_pkg::FPE_ENABLE,
         fpe_pkg::FPE_SETUP,
         fpe_pkg::FPE_ACTIVE: begin
            if (nxt[fpe_pkg::ERASE_BIT] || nxt[fpe_pkg::PROG_BIT]) begin
               state_d.phase = fpe_pkg::FPE_ACTIVE;
            end else if (nxt[fpe_pkg::ERASE_SETUP_BIT]
                         || nxt[fpe_pkg::PROG_SETUP_BIT]) begin
               state_d.phase = fpe_pkg::FPE_SETUP;
            end else if (nxt[fpe_pkg::SOFT_GATE_BIT]) begin
               state_d.phase = fpe_pkg::FPE_ENABLE;
            end else begin
               state_d.phase = fpe_pkg::FPE_IDLE;
            end
         end
         default: begin
            state_d.phase = fpe_pkg::FPE_IDLE;
         end
      endcase
      if (reset) begin
         state_d.phase = fpe_pkg::FPE_IDLE;
         state_d.rdata = fpe_pkg::READ_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      state_q <= state_d;
   end

   always_comb begin
      reg_rdata = state_q.rdata;
      // the array sees modes only through the latched bits
      flash_ctl.program_mode  = state_q.mode_ctrl[fpe_pkg::PROG_BIT];
      flash_ctl.erase_mode    = state_q.mode_ctrl[fpe_pkg::ERASE_BIT];
      flash_ctl.program_check = state_q.mode_ctrl[fpe_pkg::PROG_CHECK_BIT];
      flash_ctl.erase_check   = state_q.mode_ctrl[fpe_pkg::ERASE_CHECK_BIT];
      flash_ctl.program_setup = state_q.mode_ctrl[fpe_pkg::PROG_SETUP_BIT];
      flash_ctl.erase_setup   = state_q.mode_ctrl[fpe_pkg::ERASE_SETUP_BIT];
      erase_allowed = |(block_of(erase_addr) & state_q.block_sel);
   end

endmodule // fpe_flash_prog_erase_control

/* hdl/fpe_pkg.sv */
package fpe_pkg;

   // register offsets on the plain register port
   localparam logic [3:0] MODE_CTRL_OFS   = 4'h0;
   localparam logic [3:0] BLOCK_SEL_OFS   = 4'h2;
   localparam logic [3:0] STATUS_OFS      = 4'h4;

   // flash_mode_control field positions
   localparam int HW_GATE_BIT       = 7;
   localparam int SOFT_GATE_BIT     = 6;
   localparam int ERASE_SETUP_BIT   = 5;
   localparam int PROG_SETUP_BIT    = 4;
   localparam int ERASE_CHECK_BIT   = 3;
   localparam int PROG_CHECK_BIT    = 2;
   localparam int ERASE_BIT         = 1;
   localparam int PROG_BIT          = 0;

   // reset values
   localparam logic [7:0] MODE_CTRL_RST_HI = 8'h80;
   localparam logic [7:0] MODE_CTRL_RST_LO = 8'h00;
   localparam logic [7:0] BLOCK_SEL_RST    = 8'h00;
   localparam logic [7:0] READ_ZERO        = 8'h00;

   // operating mode codes on the mode pins
   localparam logic [2:0] OP_MODE_5 = 3'h5;
   localparam logic [2:0] OP_MODE_6 = 3'h6;
   localparam logic [2:0] OP_MODE_7 = 3'h7;

   // block base addresses, index by block bit
   localparam logic [16:0] BLOCK_BASE_0 = 17'h00000;
   localparam logic [16:0] BLOCK_BASE_1 = 17'h00400;
   localparam logic [16:0] BLOCK_BASE_2 = 17'h00800;
   localparam logic [16:0] BLOCK_BASE_3 = 17'h00C00;
   localparam logic [16:0] BLOCK_BASE_4 = 17'h01000;
   localparam logic [16:0] BLOCK_BASE_5 = 17'h08000;
   localparam logic [16:0] BLOCK_BASE_6 = 17'h10000;
   localparam logic [16:0] BLOCK_BASE_7 = 17'h18000;
   localparam logic [16:0] ARRAY_END    = 17'h1FFFF;

   typedef enum logic [1:0] {
      FPE_IDLE   = 2'b00,
      FPE_ENABLE = 2'b01,
      FPE_SETUP  = 2'b11,
      FPE_ACTIVE = 2'b10
   } fpe_phase_type;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [3:0] addr;
      logic [7:0] wdata;
   } fpe_bus_req_type;

   typedef struct packed {
      logic program_mode;
      logic erase_mode;
      logic program_check;
      logic erase_check;
      logic program_setup;
      logic erase_setup;
   } fpe_flash_ctl_type;

   typedef struct packed {
      logic [7:0]    mode_ctrl;
      logic [7:0]    block_sel;
      logic [7:0]    rdata;
      fpe_phase_type phase;
   } fpe_state_type;

endpackage

/* verif/fpe_flash_prog_erase_control_monitor.sv */
`timescale 1ns/1ps
module fpe_monitor (
   input wire logic                       clk,
   input wire logic                       reset,
   input wire logic                       hw_write_gate_pin,
   input wire logic [2:0]                 op_mode,
   input wire logic                       flash_enabled,
   input wire logic                       hw_standby,
   input wire logic                       sw_standby,
   input wire logic [3:0]                 reg_addr,
   input wire logic                       reg_read,
   input wire logic                       reg_write,
   input wire logic [7:0]                 reg_rdata,
   input wire logic                       erase_allowed,
   input wire fpe_pkg::fpe_flash_ctl_type flash_ctl
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_pin_bit;
      $past(reg_read) && $past(reg_addr) == fpe_pkg::MODE_CTRL_OFS
      && $past(flash_enabled)
      |-> reg_rdata[7] == $past(hw_write_gate_pin, 2);
   endproperty
   a_pin_bit: assert property (p_pin_bit) else $error("pin bit");
   property p_rd_off;
      $past(reg_read) && $past(reg_addr) == fpe_pkg::MODE_CTRL_OFS
      && !$past(flash_enabled) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_off: assert property (p_rd_off) else $error("read off");
   property p_prog; $rose(flash_ctl.program_mode)
      |-> $past(flash_ctl.program_setup); endproperty
   a_prog: assert property (p_prog) else $error("program early");
   property p_erase; $rose(flash_ctl.erase_mode)
      |-> $past(flash_ctl.erase_setup); endproperty
   a_erase: assert property (p_erase) else $error("erase early");
   property p_mode6; $past(op_mode) == fpe_pkg::OP_MODE_6
      |-> (flash_ctl & ~$past(flash_ctl)) == 6'h00; endproperty
   a_mode6: assert property (p_mode6) else $error("set in mode 6");
   property p_pin_low; !hw_write_gate_pin
      |=> flash_ctl == 6'h00 && !erase_allowed; endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin low");
   property p_standby; hw_standby || sw_standby
      |=> flash_ctl == 6'h00 && !erase_allowed; endproperty
   a_standby: assert property (p_standby) else $error("standby");
   property p_blk_ro; $past(reg_write) && !$past(erase_allowed)
      && $past(reg_addr) == fpe_pkg::BLOCK_SEL_OFS
      && !($past(op_mode) inside {3'h5, 3'h7}) |-> !erase_allowed;
   endproperty
   a_blk_ro: assert property (p_blk_ro) else $error("block ro");
   property p_check; $rose(flash_ctl.program_check)
      |-> $past(hw_write_gate_pin); endproperty
   a_check: assert property (p_check) else $error("verify gate");
   c_prog: cover property (flash_ctl.program_mode);
   c_erase: cover property (flash_ctl.erase_mode);
   c_allow: cover property (erase_allowed);
endmodule // fpe_monitor
bind fpe_flash_prog_erase_control fpe_monitor mon_u (.clk(clk),
   .reset(reset), .hw_write_gate_pin(hw_write_gate_pin), .op_mode(op_mode),
   .flash_enabled(flash_enabled), .hw_standby(hw_standby),
   .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_read(reg_read),
   .reg_write(reg_write), .reg_rdata(reg_rdata),
   .erase_allowed(erase_allowed), .flash_ctl(flash_ctl));

/* verif/fpe_flash_prog_erase_control_tb.sv */
`timescale 1ns/1ps
module fpe_flash_prog_erase_control_tb;
   localparam logic [3:0] CT = fpe_pkg::MODE_CTRL_OFS;
   localparam logic [3:0] BS = fpe_pkg::BLOCK_SEL_OFS;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        pin = 1'b1;
   logic [2:0]  mode = 3'h7;
   logic        fen = 1'b1;
   logic        hsb = 1'b0;
   logic        ssb = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic [16:0] eaddr = 17'h00000;
   logic        allowed;
   int          failures = 0;
   int          n_checks = 0;
   fpe_pkg::fpe_flash_ctl_type ctl;
   logic [16:0] base [8] = '{17'h00000, 17'h00400, 17'h00800, 17'h00C00,
                             17'h01000, 17'h08000, 17'h10000, 17'h18000};
   always #5 clk = ~clk;
   fpe_flash_prog_erase_control dut_u (.clk(clk), .reset(reset),
      .hw_write_gate_pin(pin), .op_mode(mode), .flash_enabled(fen),
      .hw_standby(hsb), .sw_standby(ssb), .reg_addr(addr),
      .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
      .erase_addr(eaddr), .erase_allowed(allowed), .flash_ctl(ctl));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rdr(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic rst(input logic p);
      pin <= p;
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      tally_and_finish;
   end
   initial begin
      rst(1'b1);
      rdr(CT, 8'h80);
      rdr(BS, 8'h00);
      wrr(CT, 8'h20);
      rdr(CT, 8'h80);
      wrr(CT, 8'h40);
      rdr(CT, 8'hC0);
      wrr(CT, 8'h41);
      rdr(CT, 8'hC0);
      wrr(CT, 8'h44);
      rdr(CT, 8'hC4);
      wrr(CT, 8'h40);
      wrr(CT, 8'h50);
      wrr(CT, 8'h51);
      rdr(CT, 8'hD1);
      chk({2'b00, ctl}, 8'h22);
      rdr(fpe_pkg::STATUS_OFS, 8'h02);
      wrr(CT, 8'h40);
      $display("program sequence test done");
      for (int i = 0; i < 8; i++) begin
         wrr(BS, 8'h01 << i);
         #1 eaddr <= base[i];
         #1 chk({7'h00, allowed}, 8'h01);
         eaddr <= base[i] - 17'h00001;
         #1 chk({7'h00, allowed}, 8'h00);
      end
      wrr(BS, 8'h20);
      wrr(CT, 8'h60);
      wrr(CT, 8'h62);
      rdr(CT, 8'hE2);
      chk({2'b00, ctl}, 8'h11);
      rdr(4'h8, 8'h00);
      @(posedge clk) pin <= 1'b0;
      rdr(CT, 8'h00);
      rdr(BS, 8'h00);
      @(posedge clk) pin <= 1'b1;
      rdr(CT, 8'h80);
      $display("erase and block test done");
      @(posedge clk) mode <= 3'h6;
      wrr(CT, 8'h40);
      rdr(CT, 8'h80);
      @(posedge clk) pin <= 1'b0;
      wrr(CT, 8'h40);
      rdr(CT, 8'h00);
      @(posedge clk) pin <= 1'b1;
      @(posedge clk) mode <= 3'h3;
      wrr(CT, 8'h40);
      wrr(BS, 8'h01);
      rdr(BS, 8'h00);
      @(posedge clk) mode <= 3'h5;
      wrr(BS, 8'h01);
      rdr(BS, 8'h01);
      wrr(CT, 8'h80);
      rdr(BS, 8'h00);
      wrr(BS, 8'h01);
      rdr(BS, 8'h00);
      $display("mode and interlock test done");
      for (int j = 0; j < 2; j++) begin
         wrr(CT, 8'h40);
         @(posedge clk) {hsb, ssb} <= (j == 0) ? 2'b10 : 2'b01;
         @(posedge clk) {hsb, ssb} <= 2'b00;
         rdr(CT, 8'h80);
      end
      @(posedge clk) fen <= 1'b0;
      rdr(CT, 8'h00);
      wrr(CT, 8'h40);
      @(posedge clk) fen <= 1'b1;
      rdr(CT, 8'h80);
      $display("standby and disable test done");
      rst(1'b0);
      rdr(CT, 8'h00);
      $display("low pin reset test done");
      tally_and_finish;
   end
endmodule // fpe_flash_prog_erase_control_tb
